// *** smbus_host_port.sv ***
// smbus_host_port: bus master that runs one SMBus transfer per request.
// assumes a slave without clock stretching; SCL is made here by a divider.
`timescale 1ns/10ps
`include "smbus_params.svh"
module smbus_host_port #(
  parameter int unsigned QTR_CYC = `QTR_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // bus side
  smbus_link_if.host link,
  // request
  input wire logic i_start,
  input wire smbus_pkg::op_t i_op,
  input wire logic [6:0] i_addr7,
  input wire logic [7:0] i_cmd,
  input wire logic [15:0] i_wdata,
  // answer
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic [15:0] o_rdata
);
  localparam int DW = $clog2(QTR_CYC + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(QTR_CYC - 1);

  // symbol sequence of each transfer, step 0 is always a start
  function automatic smbus_pkg::act_t plan(input smbus_pkg::op_t op,
                                           input logic [2:0] s);
    smbus_pkg::act_t a;
    a = smbus_pkg::A_STOP;
    if (s == 3'h0) begin
      a = smbus_pkg::A_START;
    end else if (op == smbus_pkg::OP_WR_BYTE) begin
      if (s <= 3'h3) a = smbus_pkg::A_WR;
    end else if (op == smbus_pkg::OP_WR_WORD) begin
      if (s <= 3'h4) a = smbus_pkg::A_WR;
    end else if (op == smbus_pkg::OP_RECV_BYTE) begin
      if (s == 3'h1) a = smbus_pkg::A_WR;
      if (s == 3'h2) a = smbus_pkg::A_RD_NACK;
    end else begin
      if (s <= 3'h2 || s == 3'h4) a = smbus_pkg::A_WR;
      if (s == 3'h3) a = smbus_pkg::A_START;
      if (s == 3'h5) a = (op == smbus_pkg::OP_RD_WORD) ?
        smbus_pkg::A_RD_ACK : smbus_pkg::A_RD_NACK;
      if (s == 3'h6 && op == smbus_pkg::OP_RD_WORD) begin
        a = smbus_pkg::A_RD_NACK;
      end
    end
    return a;
  endfunction

  smbus_pkg::mst_state_t run_q, run_d;
  smbus_pkg::op_t op_q, op_d;
  smbus_pkg::act_t act;
  logic [6:0] addr_q, addr_d;
  logic [7:0] cmd_q, cmd_d, txb, txs;
  logic [15:0] wd_q, wd_d, rx_q, rx_d;
  logic [2:0] step_q, step_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] qt_q, qt_d;
  logic [DW-1:0] div_q, div_d;
  logic abort_q, abort_d, nack_q, nack_d, done_q, done_d;
  logic scl_q, scl_d, sda_q, sda_d, sda1_q, sda2_q, wr_op, tick;

  // sda back from the wire through two flops
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sda1_q <= 1'b1;
      sda2_q <= 1'b1;
    end else begin
      sda1_q <= link.sda;
      sda2_q <= sda1_q;
    end
  end

  // sequencer: next-state logic
  always_comb begin
    run_d = run_q;
    op_d = op_q;
    addr_d = addr_q;
    cmd_d = cmd_q;
    wd_d = wd_q;
    rx_d = rx_q;
    step_d = step_q;
    bit_d = bit_q;
    qt_d = qt_q;
    div_d = div_q;
    abort_d = abort_q;
    nack_d = nack_q;
    done_d = 1'b0;
    scl_d = 1'b1;
    sda_d = 1'b1;
    wr_op = (op_q == smbus_pkg::OP_WR_BYTE) ||
      (op_q == smbus_pkg::OP_WR_WORD);
    act = abort_q ? smbus_pkg::A_STOP : plan(op_q, step_q);
    unique case (step_q)
      3'h1: txb = {addr_q, op_q == smbus_pkg::OP_RECV_BYTE};
      3'h2: txb = cmd_q;
      3'h3: txb = wd_q[7:0];
      default: txb = wr_op ? wd_q[15:8] : {addr_q, 1'b1};
    endcase
    txs = txb << bit_q[2:0];
    tick = (div_q == DIV_LAST);
    if (run_q == smbus_pkg::M_IDLE) begin
      if (i_start) begin
        run_d = smbus_pkg::M_RUN;
        op_d = i_op;
        addr_d = i_addr7;
        cmd_d = i_cmd;
        wd_d = i_wdata;
        step_d = 3'h0;
        bit_d = 4'h0;
        qt_d = 2'h0;
        div_d = '0;
        abort_d = 1'b0;
        nack_d = 1'b0;
      end
    end else begin
      // line levels: data bits move SDA in quarter 1 with SCL low; start and stop move it in quarter 3, with SCL high
      scl_d = qt_q[1];
      if (qt_q == 2'h0) begin
        sda_d = sda_q;
      end else begin
        unique case (act)
          smbus_pkg::A_START: sda_d = (qt_q != 2'h3);
          smbus_pkg::A_STOP: sda_d = (qt_q == 2'h3);
          smbus_pkg::A_WR: sda_d = (bit_q < `BITS_PER_BYTE) ? txs[7] :
            1'b1;
          smbus_pkg::A_RD_ACK: sda_d = (bit_q < `BITS_PER_BYTE) ? 1'b1 :
            1'b0;
          smbus_pkg::A_RD_NACK: sda_d = 1'b1;
        endcase
      end
      div_d = tick ? '0 : div_q + 1'b1;
      if (tick) begin
        qt_d = qt_q + 2'h1;
        if (qt_q == 2'h3) begin
          // end of a symbol: sample, then advance
          if (act == smbus_pkg::A_WR && bit_q == `BITS_PER_BYTE &&
              sda2_q) begin
            nack_d = 1'b1;
            abort_d = 1'b1;
          end
          if ((act == smbus_pkg::A_RD_ACK || act == smbus_pkg::A_RD_NACK)
              && bit_q < `BITS_PER_BYTE) begin
            rx_d = {rx_q[14:0], sda2_q};
          end
          if ((act == smbus_pkg::A_WR || act == smbus_pkg::A_RD_ACK ||
               act == smbus_pkg::A_RD_NACK) && bit_q < `BITS_PER_BYTE) begin
            bit_d = bit_q + 4'h1;
          end else begin
            bit_d = 4'h0;
            step_d = step_q + 3'h1;
            if (act == smbus_pkg::A_STOP) begin
              run_d = smbus_pkg::M_IDLE;
              done_d = 1'b1;
            end
          end
        end
      end
    end
  end

  // sequencer: registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      run_q <= smbus_pkg::M_IDLE;
      op_q <= smbus_pkg::OP_WR_BYTE;
      addr_q <= 7'h00;
      cmd_q <= 8'h00;
      wd_q <= 16'h0000;
      rx_q <= 16'h0000;
      step_q <= 3'h0;
      bit_q <= 4'h0;
      qt_q <= 2'h0;
      div_q <= '0;
      abort_q <= 1'b0;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      run_q <= run_d;
      op_q <= op_d;
      addr_q <= addr_d;
      cmd_q <= cmd_d;
      wd_q <= wd_d;
      rx_q <= rx_d;
      step_q <= step_d;
      bit_q <= bit_d;
      qt_q <= qt_d;
      div_q <= div_d;
      abort_q <= abort_d;
      nack_q <= nack_d;
      done_q <= done_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  // open drain outputs pull low only
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = ~scl_q;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = ~sda_q;
  assign o_busy = (run_q == smbus_pkg::M_RUN);
  assign o_done = done_q;
  assign o_nack = nack_q;
  assign o_rdata = rx_q;
endmodule // smbus_host_port

// *** smbus_link_if.sv ***
// smbus_link_if: the two open-drain bus wires between master and slave.
// each driver gives output and enable; the wired-AND level is formed here.
`timescale 1ns/10ps
interface smbus_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic serial_data_out_driver_o;
  logic serial_data_out_driver_oe;
  logic scl;
  logic sda;
  // pull-up wins unless someone drives
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
    (serial_data_out_driver_oe ? serial_data_out_driver_o : 1'b1);
  modport device (input scl, input sda, output serial_data_out_driver_o,
    output serial_data_out_driver_oe);
  modport host (input scl, input sda, output host_scl_o,
    output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// *** smbus_link_monitor.sv ***
// smbus_link_monitor: assertions on the open-drain link wires.
// assumes wires resolved by the interface, core clock i_mclk.
`timescale 1ns/10ps
module smbus_link_monitor #(
  parameter int unsigned TIMEOUT_CYC = 200
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // link wires
  input wire logic host_sda_oe,
  input wire logic serial_data_out_driver_o,
  input wire logic serial_data_out_driver_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  int unsigned drv_cnt_q;
  int unsigned drv_cnt_d;
  // run length of device drive; slack covers the line filter delay
  always_comb begin
    drv_cnt_d = serial_data_out_driver_oe ? drv_cnt_q + 1 : 0;
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      drv_cnt_q <= 0;
    end else begin
      drv_cnt_q <= drv_cnt_d;
    end
  end
  // device low level held over a whole clock high pulse
  sequence s_held_high;
    serial_data_out_driver_oe [*6];
  endsequence
  // stop: data rises while clock stays high
  sequence s_stop_seen;
    $rose(sda) && scl && $past(scl);
  endsequence
  a_drive_only_low: assert property (
    serial_data_out_driver_oe |-> !serial_data_out_driver_o)
    else $error("device drives data high");
  a_dev_edge_scl_low: assert property (
    $changed(serial_data_out_driver_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_one_driver_high: assert property (
    scl |-> !(host_sda_oe && serial_data_out_driver_oe))
    else $error("both ends drive data during clock high");
  a_ack_whole_pulse: assert property (
    $rose(scl) && serial_data_out_driver_oe |-> s_held_high)
    else $error("device low level dropped inside clock pulse");
  a_drive_after_fall: assert property (
    $rose(serial_data_out_driver_oe) |-> !scl && !$past(scl)
      && !$past(scl, 2) && !$past(scl, 3))
    else $error("device drove data before filtered clock fall");
  a_idle_after_stop: assert property (
    s_stop_seen |-> !serial_data_out_driver_oe [*8])
    else $error("device drives data after stop");
  a_idle_after_reset: assert property (
    $fell(i_rst) |-> !serial_data_out_driver_oe [*4])
    else $error("device drives data right after reset");
  a_stuck_release: assert property (
    drv_cnt_q <= TIMEOUT_CYC + 8)
    else $error("device held data low past the timeout");
endmodule // smbus_link_monitor

// *** smbus_monitor_slave_port_tb_top.sv ***
// smbus_monitor_slave_port_tb_top: host and slave ends joined on one link.
// assumes a core model here that serves eight byte registers.
`timescale 1ns/10ps
`include "smbus_params.svh"
module smbus_monitor_slave_port_tb_top;
  localparam int unsigned TO_CYC = 1000;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic start = 1'b0;
  smbus_pkg::op_t op = smbus_pkg::OP_WR_BYTE;
  logic [6:0] addr7 = 7'h00;
  logic [7:0] cmd = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic busy, done, nack, rd_stb, wr_stb, alert_rel;
  logic [15:0] rdata;
  logic [2:0] reg_ptr;
  logic [7:0] wr_data, rd_data;
  smbus_pkg::tri_pin_t pin_a = smbus_pkg::PIN_LOW;
  smbus_pkg::tri_pin_t pin_b = smbus_pkg::PIN_LOW;
  smbus_pkg::tri_pin_t pin_c = smbus_pkg::PIN_LOW;
  logic mass_en = 1'b0;
  logic alert = 1'b0;
  logic [6:0] own = 7'h4C;
  logic [7:0] regs [8];
  int bad_count = 0;
  int compares = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  smbus_link_if link ();
  smbus_host_port u_smbus_host_port (.i_mclk(i_mclk), .i_rst(i_rst),
    .link(link), .i_start(start), .i_op(op), .i_addr7(addr7),
    .i_cmd(cmd), .i_wdata(wdata), .o_busy(busy), .o_done(done),
    .o_nack(nack), .o_rdata(rdata));
  smbus_slave_port #(.TIMEOUT_CYC(TO_CYC)) u_smbus_slave_port (
    .i_mclk(i_mclk), .i_rst(i_rst), .link(link),
    .i_addr_select_pin_a(pin_a), .i_addr_select_pin_b(pin_b),
    .i_addr_select_pin_c(pin_c), .i_mass_write_en(mass_en),
    .i_alert_active(alert), .i_rd_data(rd_data), .o_reg_ptr(reg_ptr),
    .o_rd_stb(rd_stb), .o_wr_stb(wr_stb), .o_wr_data(wr_data),
    .o_alert_release(alert_rel));
  smbus_link_monitor #(.TIMEOUT_CYC(TO_CYC)) u_smbus_link_monitor (
    .i_mclk(i_mclk), .i_rst(i_rst), .host_sda_oe(link.host_sda_oe),
    .serial_data_out_driver_o(link.serial_data_out_driver_o),
    .serial_data_out_driver_oe(link.serial_data_out_driver_oe),
    .scl(link.scl), .sda(link.sda));
  // 100 MHz core clock
  always #5 i_mclk = ~i_mclk;
  // core model: read data follows the pointer within the cycle
  assign rd_data = regs[reg_ptr];
  always @(posedge i_mclk) begin
    if (wr_stb === 1'b1) begin
      regs[reg_ptr] <= wr_data;
      wr_cnt <= wr_cnt + 1;
    end
    if (alert_rel === 1'b1) begin
      alert <= 1'b0;
    end
    // read strobes counted so each served byte can be checked
    if (rd_stb === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
  end
  task automatic test_done;
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  // one transfer; the acknowledge outcome is judged on return
  task automatic run(input smbus_pkg::op_t o, input logic [6:0] a,
      input logic [7:0] c, input logic [15:0] w, input logic en);
    int n;
    @(posedge i_mclk);
    start <= 1'b1;
    op <= o;
    addr7 <= a;
    cmd <= c;
    wdata <= w;
    @(posedge i_mclk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= 5000) begin
      bad_count++;
      test_done();
    end
    chk({15'h0, en}, {15'h0, nack});
    chk(16'h0000, {15'h0, busy});
  endtask
  task automatic t_word;
    int w0;
    w0 = wr_cnt;
    run(smbus_pkg::OP_WR_WORD, own, 8'hD5, 16'h773C, 1'b0);
    chk(16'h3C16, {regs[5], regs[6]});
    chk(16'(w0 + 1), 16'(wr_cnt));
    run(smbus_pkg::OP_RD_WORD, own, 8'hD5, 16'h0000, 1'b0);
    chk(16'h3C16, rdata);
    run(smbus_pkg::OP_RD_WORD, own, 8'hD7, 16'h0000, 1'b0);
    chk(16'h1710, rdata);
  endtask
  task automatic t_byte_rw;
    int r0;
    run(smbus_pkg::OP_WR_BYTE, own, 8'hD2, 16'h00A5, 1'b0);
    chk(16'h00A5, {8'h00, regs[2]});
    r0 = rd_cnt;
    run(smbus_pkg::OP_RD_BYTE, own, 8'hD2, 16'h0000, 1'b0);
    chk(16'h00A5, {8'h00, rdata[7:0]});
    chk(16'(r0 + 1), 16'(rd_cnt));
    chk(16'h0002, {13'h0, reg_ptr});
  endtask
  // commands just outside the range and a foreign address
  task automatic t_refuse;
    int w0;
    w0 = wr_cnt;
    run(smbus_pkg::OP_WR_BYTE, own, 8'hCF, 16'h0055, 1'b1);
    run(smbus_pkg::OP_WR_BYTE, own, 8'hD8, 16'h0055, 1'b1);
    run(smbus_pkg::OP_WR_BYTE, own ^ 7'h01, 8'hD1, 16'h0055, 1'b1);
    chk(16'(w0), 16'(wr_cnt));
  endtask
  task automatic t_mass;
    mass_en <= 1'b1;
    run(smbus_pkg::OP_WR_BYTE, `MASS_WR_ADDR, 8'hD0, 16'h00C3, 1'b0);
    chk(16'h00C3, {8'h00, regs[0]});
    mass_en <= 1'b0;
    run(smbus_pkg::OP_WR_BYTE, `MASS_WR_ADDR, 8'hD0, 16'h003C, 1'b1);
    chk(16'h00C3, {8'h00, regs[0]});
  endtask
  task automatic t_alert;
    alert <= 1'b1;
    run(smbus_pkg::OP_RECV_BYTE, `ALERT_RESP_ADDR, 8'h00, 16'h0, 1'b0);
    chk({8'h00, own, 1'b0}, {8'h00, rdata[7:0]});
    chk(16'h0000, {15'h0, alert});
    alert <= 1'b1;
    run(smbus_pkg::OP_WR_BYTE, own, 8'hD1, 16'h0042, 1'b0);
    chk(16'h0000, {15'h0, alert});
    run(smbus_pkg::OP_RECV_BYTE, `ALERT_RESP_ADDR, 8'h00, 16'h0, 1'b1);
  endtask
  // new strap setting: new address answers, the previous one no longer
  task automatic t_strap(input smbus_pkg::tri_pin_t c,
      input smbus_pkg::tri_pin_t b, input smbus_pkg::tri_pin_t a,
      input logic [6:0] ad, input logic [6:0] old);
    @(posedge i_mclk);
    pin_c <= c;
    pin_b <= b;
    pin_a <= a;
    repeat (4) @(posedge i_mclk);
    own = ad;
    run(smbus_pkg::OP_WR_BYTE, ad, 8'hD3, {9'h0, ad}, 1'b0);
    chk({9'h0, ad}, {8'h00, regs[3]});
    run(smbus_pkg::OP_WR_BYTE, old, 8'hD3, 16'h0000, 1'b1);
  endtask
  // main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      regs[i] = 8'(16 + i);
    end
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_mclk);
    t_word;
    t_byte_rw;
    t_refuse;
    t_mass;
    t_alert;
    t_strap(smbus_pkg::PIN_LOW, smbus_pkg::PIN_HIGH, smbus_pkg::PIN_OPEN,
      7'h45, 7'h4C);
    t_strap(smbus_pkg::PIN_OPEN, smbus_pkg::PIN_OPEN, smbus_pkg::PIN_OPEN,
      7'h56, 7'h45);
    t_strap(smbus_pkg::PIN_HIGH, smbus_pkg::PIN_HIGH, smbus_pkg::PIN_LOW,
      7'h76, 7'h56);
    t_strap(smbus_pkg::PIN_LOW, smbus_pkg::PIN_LOW, smbus_pkg::PIN_LOW,
      7'h4C, 7'h76);
    test_done();
  end
endmodule // smbus_monitor_slave_port_tb_top

// *** smbus_params.svh ***
// smbus_params.svh: addresses, command range and timing counts for the
// monitor slave port and its bus master; included by both ends.
`ifndef SMBUS_PARAMS_SVH
`define SMBUS_PARAMS_SVH
`define MASS_WR_ADDR 7'h63
`define ALERT_RESP_ADDR 7'h0C
`define CMD_FIRST 8'hD0
`define CMD_LAST 8'hD7
`define TIMEOUT_MS 25
`define CLK_PERIOD_NS 10
`define TIMEOUT_CYC (`TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)
`define BITS_PER_BYTE 4'h8
`define SYNC_RST 8'h03
`define QTR_CYC 3
`endif

// *** smbus_pkg.sv ***
// smbus_pkg: types shared by the slave port and the bus master.
// assumes nothing beyond a SystemVerilog compiler.
package smbus_pkg;
  // three-level strap pin as seen by the slave
  typedef enum logic [1:0] {
    PIN_LOW = 2'h0, PIN_HIGH = 2'h1, PIN_OPEN = 2'h2
  } tri_pin_t;
  // transfer kinds the master can run
  typedef enum logic [2:0] {
    OP_WR_BYTE = 3'h0, OP_WR_WORD = 3'h1, OP_RD_BYTE = 3'h2,
    OP_RD_WORD = 3'h3, OP_RECV_BYTE = 3'h4
  } op_t;
  // slave byte-engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_RX = 3'h1, ST_ACK = 3'h3, ST_TX = 3'h2,
    ST_MACK = 3'h6, ST_WAIT = 3'h7
  } slv_state_t;
  // which byte of a frame the slave is receiving
  typedef enum logic [1:0] {
    K_ADDR = 2'h0, K_CMD = 2'h1, K_DATA1 = 2'h3, K_EXTRA = 2'h2
  } byte_kind_t;
  // master symbol actions
  typedef enum logic [2:0] {
    A_START = 3'h0, A_WR = 3'h1, A_RD_ACK = 3'h3, A_RD_NACK = 3'h2,
    A_STOP = 3'h6
  } act_t;
  typedef enum logic {M_IDLE = 1'b0, M_RUN = 1'b1} mst_state_t;
endpackage

// *** smbus_slave_port.sv ***
// smbus_slave_port: two-wire read-write slave port of a monitor controller.
// assumes bus lines and strap pins are asynchronous; core side is i_mclk.
// Behaviour
// - serves read/write byte and read/write word
// - read word second byte is next register
// - write word second data byte acked, dropped
// - line low past 25ms resets, releases SDA
// - unsupported command byte gets no acknowledge
// - start and stop detected while SCL high
// - idle when both high; ready after stop
// - three tri-level pins pick 27 addresses
// - accept writes to mass-write broadcast address
// - mass-write ignored while enable bit low
// - alert response address answered with own address
// - transmitter releases SDA during acknowledge pulse
// - receiver holds SDA low whole ack pulse
// - master acks all reads but last, stops
// - master may stop after a slave nack
// - write opens start, address, write bit
// - acked command low bits load pointer
// - read uses repeated start, read bit set
// - addressing at own address releases alert
`timescale 1ns/10ps
`include "smbus_params.svh"
module smbus_slave_port #(
  parameter int unsigned TIMEOUT_CYC = `TIMEOUT_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // bus side
  smbus_link_if.device link,
  // address strap pins
  input wire smbus_pkg::tri_pin_t i_addr_select_pin_a,
  input wire smbus_pkg::tri_pin_t i_addr_select_pin_b,
  input wire smbus_pkg::tri_pin_t i_addr_select_pin_c,
  // controller core side
  input wire logic i_mass_write_en,
  input wire logic i_alert_active,
  input wire logic [7:0] i_rd_data,
  output logic [2:0] o_reg_ptr,
  output logic o_rd_stb,
  output logic o_wr_stb,
  output logic [7:0] o_wr_data,
  output logic o_alert_release
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TO_MAX = TW'(TIMEOUT_CYC);
  localparam smbus_pkg::tri_pin_t PL = smbus_pkg::PIN_LOW;
  localparam smbus_pkg::tri_pin_t PH = smbus_pkg::PIN_HIGH;
  localparam smbus_pkg::tri_pin_t PO = smbus_pkg::PIN_OPEN;

  // strap code {c,b,a} to the 7-bit slave address
  function automatic logic [6:0] own_addr(input logic [5:0] p);
    logic [7:0] w;
    w = 8'h00;
    case (p)
      {PL, PO, PL}: w = 8'h88;
      {PL, PH, PO}: w = 8'h8A;
      {PL, PO, PO}: w = 8'h8C;
      {PL, PO, PH}: w = 8'h8E;
      {PL, PL, PL}: w = 8'h98;
      {PL, PH, PH}: w = 8'h9A;
      {PL, PL, PO}: w = 8'h9C;
      {PL, PL, PH}: w = 8'h9E;
      {PO, PO, PL}: w = 8'hA8;
      {PO, PH, PO}: w = 8'hAA;
      {PO, PO, PO}: w = 8'hAC;
      {PO, PO, PH}: w = 8'hAE;
      {PO, PL, PL}: w = 8'hB8;
      {PO, PH, PH}: w = 8'hBA;
      {PO, PL, PO}: w = 8'hBC;
      {PO, PL, PH}: w = 8'hBE;
      {PH, PO, PL}: w = 8'hC8;
      {PH, PH, PO}: w = 8'hCA;
      {PH, PO, PO}: w = 8'hCC;
      {PH, PO, PH}: w = 8'hCE;
      {PH, PL, PL}: w = 8'hD8;
      {PH, PH, PH}: w = 8'hDA;
      {PH, PL, PO}: w = 8'hDC;
      {PH, PL, PH}: w = 8'hDE;
      {PL, PH, PL}: w = 8'hE8;
      {PO, PH, PL}: w = 8'hEA;
      {PH, PH, PL}: w = 8'hEC;
      default: w = 8'h00;
    endcase
    return w[7:1];
  endfunction

  // two-flop synchroniser plus one compare stage, bit 1 scl, bit 0 sda
  logic [7:0] pin_in;
  logic [7:0] s1_q, s2_q, s3_q;
  assign pin_in = {i_addr_select_pin_c, i_addr_select_pin_b,
    i_addr_select_pin_a, link.scl, link.sda};
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= `SYNC_RST;
      s2_q <= `SYNC_RST;
      s3_q <= `SYNC_RST;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per line: one-cycle glitch filter and stuck-low timer
  logic f_q [2];
  logic f_d [2];
  logic to_hit [2];
  logic [TW-1:0] to_q [2];
  logic [TW-1:0] to_d [2];
  for (genvar g = 0; g < 2; g++) begin : g_line
    always_comb begin
      f_d[g] = (s2_q[g] == s3_q[g]) ? s2_q[g] : f_q[g];
      if (f_q[g]) begin
        to_d[g] = '0;
      end else if (to_q[g] == TO_MAX) begin
        to_d[g] = TO_MAX;
      end else begin
        to_d[g] = to_q[g] + 1'b1;
      end
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        f_q[g] <= 1'b1;
        to_q[g] <= '0;
      end else begin
        f_q[g] <= f_d[g];
        to_q[g] <= to_d[g];
      end
    end
    assign to_hit[g] = (to_q[g] == TO_MAX);
  end

  // bus events from the filtered lines
  logic timeout, start, stop, scl_rise, scl_fall;
  logic [6:0] own;
  assign timeout = to_hit[0] | to_hit[1];
  assign start = f_q[1] & f_d[1] & f_q[0] & ~f_d[0];
  assign stop = f_q[1] & f_d[1] & ~f_q[0] & f_d[0];
  assign scl_rise = ~f_q[1] & f_d[1];
  assign scl_fall = f_q[1] & ~f_d[1];
  assign own = own_addr(s2_q[7:2]);

  smbus_pkg::slv_state_t st_q, st_d;
  smbus_pkg::byte_kind_t kind_q, kind_d;
  logic [3:0] bcnt_q, bcnt_d;
  logic [7:0] sh_q, sh_d, wdat_q, wdat_d;
  logic [2:0] ptr_q, ptr_d;
  logic rd_q, rd_d, ara_q, ara_d, oe_q, oe_d;
  logic rds_q, rds_d, wrs_q, wrs_d, rel_q, rel_d;
  logic ack, load;

  // byte engine: next-state logic
  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    bcnt_d = bcnt_q;
    sh_d = sh_q;
    wdat_d = wdat_q;
    ptr_d = ptr_q;
    rd_d = rd_q;
    ara_d = ara_q;
    oe_d = oe_q;
    rds_d = 1'b0;
    wrs_d = 1'b0;
    rel_d = 1'b0;
    ack = 1'b0;
    load = 1'b0;
    if (timeout) begin
      st_d = smbus_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else if (start) begin
      st_d = smbus_pkg::ST_RX;
      kind_d = smbus_pkg::K_ADDR;
      bcnt_d = 4'h0;
      rd_d = 1'b0;
      ara_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop) begin
      st_d = smbus_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        smbus_pkg::ST_IDLE, smbus_pkg::ST_WAIT: begin
        end
        smbus_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], f_d[0]};
            bcnt_d = bcnt_q + 4'h1;
          end else if (scl_fall && bcnt_q == `BITS_PER_BYTE) begin
            unique case (kind_q)
              smbus_pkg::K_ADDR: begin
                if (sh_q[7:1] == own) begin
                  ack = 1'b1;
                  rel_d = 1'b1;
                  rd_d = sh_q[0];
                end else if (sh_q[7:1] == `MASS_WR_ADDR && !sh_q[0] &&
                             i_mass_write_en) begin
                  ack = 1'b1;
                end else if (sh_q[7:1] == `ALERT_RESP_ADDR && sh_q[0] &&
                             i_alert_active) begin
                  ack = 1'b1;
                  ara_d = 1'b1;
                  rd_d = 1'b1;
                end
                kind_d = smbus_pkg::K_CMD;
              end
              smbus_pkg::K_CMD: begin
                ack = (sh_q >= `CMD_FIRST) && (sh_q <= `CMD_LAST);
                kind_d = smbus_pkg::K_DATA1;
              end
              smbus_pkg::K_DATA1: begin
                ack = 1'b1;
                wrs_d = 1'b1;
                wdat_d = sh_q;
                kind_d = smbus_pkg::K_EXTRA;
              end
              smbus_pkg::K_EXTRA: begin
                ack = 1'b1;
              end
            endcase
            st_d = ack ? smbus_pkg::ST_ACK : smbus_pkg::ST_WAIT;
            oe_d = ack;
          end
        end
        smbus_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (kind_q == smbus_pkg::K_DATA1) begin
              ptr_d = sh_q[2:0];
            end
            if (rd_q) begin
              load = 1'b1;
            end else begin
              st_d = smbus_pkg::ST_RX;
              bcnt_d = 4'h0;
              oe_d = 1'b0;
            end
          end
        end
        smbus_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bcnt_q == `BITS_PER_BYTE) begin
              oe_d = 1'b0;
              st_d = smbus_pkg::ST_MACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
              bcnt_d = bcnt_q + 4'h1;
            end
          end
        end
        smbus_pkg::ST_MACK: begin
          if (scl_rise) begin
            rel_d = ara_q;
            if (f_d[0]) begin
              st_d = smbus_pkg::ST_WAIT;
            end else begin
              ptr_d = ptr_q + 3'h1;
              bcnt_d = 4'h0;
            end
          end else if (scl_fall && bcnt_q == 4'h0) begin
            load = 1'b1;
          end
        end
      endcase
    end
    // load the next byte to send and drive its first bit
    if (load) begin
      sh_d = ara_q ? {own, 1'b0} : i_rd_data;
      rds_d = ~ara_q;
      oe_d = ara_q ? ~own[6] : ~i_rd_data[7];
      bcnt_d = 4'h1;
      st_d = smbus_pkg::ST_TX;
    end
  end

  // byte engine: registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= smbus_pkg::ST_IDLE;
      kind_q <= smbus_pkg::K_ADDR;
      bcnt_q <= 4'h0;
      sh_q <= 8'h00;
      wdat_q <= 8'h00;
      ptr_q <= 3'h0;
      rd_q <= 1'b0;
      ara_q <= 1'b0;
      oe_q <= 1'b0;
      rds_q <= 1'b0;
      wrs_q <= 1'b0;
      rel_q <= 1'b0;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      bcnt_q <= bcnt_d;
      sh_q <= sh_d;
      wdat_q <= wdat_d;
      ptr_q <= ptr_d;
      rd_q <= rd_d;
      ara_q <= ara_d;
      oe_q <= oe_d;
      rds_q <= rds_d;
      wrs_q <= wrs_d;
      rel_q <= rel_d;
    end
  end

  // open drain: only ever pulls low
  assign link.serial_data_out_driver_o = 1'b0;
  assign link.serial_data_out_driver_oe = oe_q;
  assign o_reg_ptr = ptr_q;
  assign o_rd_stb = rds_q;
  assign o_wr_stb = wrs_q;
  assign o_wr_data = wdat_q;
  assign o_alert_release = rel_q;
endmodule // smbus_slave_port
